// ===== verilog/block_ram_pkg.sv
// package with constants for the configurable block ram
package block_ram_pkg;
	localparam int SIZE_SMALL = 0;
	localparam int SIZE_MEDIUM = 1;
	localparam int SIZE_LARGE = 2;
	localparam int SMALL_WORDS = 32;
	localparam int SMALL_BITS = 18;
	localparam int MEDIUM_WORDS = 128;
	localparam int MEDIUM_BITS = 36;
	localparam int LARGE_WORDS = 4096;
	localparam int LARGE_BITS = 144;
	localparam int BYTE_BITS = 9; // eight data bits plus parity
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_SIMPLE_DUAL = 2'h1;
	localparam logic [1:0] MODE_TRUE_DUAL = 2'h2;
	localparam logic RDW_OLD_DATA = 1'h0;
	localparam logic RDW_UNDEFINED = 1'h1;
	localparam logic [8:0] UNDEFINED_FILL = 9'h1AA; // pattern shown for don't-care reads
endpackage

// ===== verilog/ram_input_stage.sv
// input register stage of one ram port with asynchronous clear
`timescale 1ns/1ps
module ram_input_stage
	import block_ram_pkg::*;
#(
	parameter int AW = 7,
	parameter int DW = 36,
	parameter int BW = 4,
	parameter bit HAS_CLEAR = 1'b1
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic aclr_in,
	input wire logic clken_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [DW-1:0] data_in,
	input wire logic [BW-1:0] byteen_in,
	input wire logic wren_in,
	input wire logic rden_in,
	output logic [AW-1:0] addr_out,
	output logic [DW-1:0] data_out,
	output logic [BW-1:0] byteen_out,
	output logic wren_out,
	output logic rden_out
);
	logic clr;
	logic [AW-1:0] next_addr;
	logic [DW-1:0] next_data;
	logic [BW-1:0] next_byteen;
	logic next_wren;
	logic next_rden;

	initial begin
		if (AW < 1 || DW < 1 || BW < 1) $error("ram_input_stage: bad width");
	end

	// clear only where the block size has input clears
	assign clr = HAS_CLEAR && aclr_in;

	// capture next values while the clock enable is high
	always_comb begin
		next_addr = addr_out;
		next_data = data_out;
		next_byteen = byteen_out;
		next_wren = wren_out;
		next_rden = rden_out;
		if (clken_in) begin
			next_addr = addr_in;
			next_data = data_in;
			next_byteen = byteen_in;
			next_wren = wren_in;
			next_rden = rden_in;
		end
	end

	// registers, cleared at once by the port clear
	always_ff @(posedge clk_in or negedge rst_b_in or posedge clr) begin
		if (!rst_b_in || clr) begin
			addr_out <= '0;
			data_out <= '0;
			byteen_out <= '0;
			wren_out <= 1'b0;
			rden_out <= 1'b0;
		end else begin
			addr_out <= next_addr;
			data_out <= next_data;
			byteen_out <= next_byteen;
			wren_out <= next_wren;
			rden_out <= next_rden;
		end
	end
endmodule

// ===== verilog/ram_output_stage.sv
// optional output register of one ram port with immediate clear
`timescale 1ns/1ps
module ram_output_stage #(
	parameter int DW = 36
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic aclr_in,
	input wire logic clken_in,
	input wire logic bypass_in,
	input wire logic [DW-1:0] array_in,
	output logic [DW-1:0] q_out
);
	logic [DW-1:0] q_reg;
	logic [DW-1:0] next_q;

	initial begin
		if (DW < 1) $error("ram_output_stage: bad width");
	end

	// hold the word while the output clock enable is low
	always_comb begin
		next_q = q_reg;
		if (clken_in) begin
			next_q = array_in;
		end
	end

	// output register with asynchronous clear
	always_ff @(posedge clk_in or negedge rst_b_in or posedge aclr_in) begin
		if (!rst_b_in || aclr_in) begin
			q_reg <= '0;
		end else begin
			q_reg <= next_q;
		end
	end

	// bypass gives array data directly; clear forces zero at once
	always_comb begin
		if (aclr_in) begin
			q_out = '0;
		end else if (bypass_in) begin
			q_out = array_in;
		end else begin
			q_out = q_reg;
		end
	end
endmodule

// ===== verilog/configurable_block_ram.sv
// configurable embedded ram block with two ports, mixed widths and clears
`timescale 1ns/1ps
module configurable_block_ram
	import block_ram_pkg::*;
#(
	parameter int SIZE = SIZE_MEDIUM,
	parameter int DEPTH = (SIZE == SIZE_SMALL) ? SMALL_WORDS : (SIZE == SIZE_MEDIUM) ? MEDIUM_WORDS : LARGE_WORDS,
	parameter int WIDTH = (SIZE == SIZE_SMALL) ? SMALL_BITS : (SIZE == SIZE_MEDIUM) ? MEDIUM_BITS : LARGE_BITS,
	parameter int RATIO_A = 1,
	parameter int RATIO_B = 1,
	parameter bit PRELOAD = 1'b0,
	parameter logic [WIDTH-1:0] PRELOAD_WORD = '0
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [1:0] mode_in,
	input wire logic rdw_select_in,
	input wire logic flow_through_in,
	input wire logic bypass_a_in,
	input wire logic bypass_b_in,
	input wire logic split_in,
	input wire logic in_aclr_in,
	input wire logic out_aclr_in,
	input wire logic in_clken_in,
	input wire logic out_clken_in,
	input wire logic [$clog2(DEPTH*RATIO_A)-1:0] addr_a_in,
	input wire logic [WIDTH/RATIO_A-1:0] data_a_in,
	input wire logic [(WIDTH/RATIO_A+BYTE_BITS-1)/BYTE_BITS-1:0] byteen_a_in,
	input wire logic wren_a_in,
	input wire logic rden_a_in,
	input wire logic [$clog2(DEPTH*RATIO_B)-1:0] addr_b_in,
	input wire logic [WIDTH/RATIO_B-1:0] data_b_in,
	input wire logic [(WIDTH/RATIO_B+BYTE_BITS-1)/BYTE_BITS-1:0] byteen_b_in,
	input wire logic wren_b_in,
	input wire logic rden_b_in,
	output logic [WIDTH/RATIO_A-1:0] q_a_out,
	output logic [WIDTH/RATIO_B-1:0] q_b_out,
	output logic [(WIDTH/RATIO_B+BYTE_BITS-1)/BYTE_BITS-1:0] parity_err_b_out
);
	localparam int AW = $clog2(DEPTH);
	localparam int WA = WIDTH / RATIO_A;
	localparam int WB = WIDTH / RATIO_B;
	localparam int AWA = $clog2(DEPTH * RATIO_A);
	localparam int AWB = $clog2(DEPTH * RATIO_B);
	localparam int BEA = (WA + BYTE_BITS - 1) / BYTE_BITS;
	localparam int BEB = (WB + BYTE_BITS - 1) / BYTE_BITS;
	localparam bit IN_CLEARS = (SIZE != SIZE_LARGE);
	localparam bit BYTE_ENABLES = (SIZE != SIZE_SMALL);

	// refuse shapes the array cannot serve
	initial begin
		if (SIZE < SIZE_SMALL || SIZE > SIZE_LARGE) $error("bad size");
		if (WIDTH % RATIO_A != 0 || WIDTH % RATIO_B != 0) $error("ratio must divide width");
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
		if (PRELOAD && SIZE == SIZE_LARGE) $error("large block cannot be preloaded");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AWA-1:0] ra_addr;
	logic [WA-1:0] ra_data;
	logic [BEA-1:0] ra_be;
	logic ra_wren;
	logic ra_rden;
	logic [AWB-1:0] rb_addr;
	logic [WB-1:0] rb_data;
	logic [BEB-1:0] rb_be;
	logic rb_wren;
	logic [AWB-1:0] fall_addr;
	logic fall_rden;
	logic [AWB-1:0] rd_addr_b;
	logic rd_en_b;
	logic [WA-1:0] word_a;
	logic [WB-1:0] word_b;
	logic [WB-1:0] next_word_b;
	logic [WA-1:0] next_word_a;
	logic dual_ok;
	logic flow_ok;
	logic en_wr_a;
	logic en_wr_b;
	logic [AWB-1:0] rd_addr_q;
	logic rd_en_q;
	logic [AWB-1:0] next_rd_addr_q;
	logic next_rd_en_q;
	logic rdw_hit;

	// byte-lane parity check: returns 1 per lane whose odd parity fails
	function automatic logic [BEB-1:0] parity_fail(input logic [WB-1:0] w);
		logic [BEB-1:0] r;
		r = '0;
		for (int i = 0; i < BEB; i++) begin
			if (i * BYTE_BITS + BYTE_BITS <= WB) begin
				r[i] = ~(^w[i*BYTE_BITS +: BYTE_BITS]);
			end
		end
		return r;
	endfunction

	// don't-care pattern repeated across the read word
	function automatic logic [WB-1:0] fill_word();
		logic [WB-1:0] r;
		for (int i = 0; i < WB; i++) begin
			r[i] = UNDEFINED_FILL[i % BYTE_BITS];
		end
		return r;
	endfunction

	// port input registers
	ram_input_stage #(.AW(AWA), .DW(WA), .BW(BEA), .HAS_CLEAR(IN_CLEARS)) u_in_a (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.aclr_in(in_aclr_in),
		.clken_in(in_clken_in),
		.addr_in(addr_a_in),
		.data_in(data_a_in),
		.byteen_in(byteen_a_in),
		.wren_in(wren_a_in),
		.rden_in(rden_a_in),
		.addr_out(ra_addr),
		.data_out(ra_data),
		.byteen_out(ra_be),
		.wren_out(ra_wren),
		.rden_out(ra_rden)
	);

	ram_input_stage #(.AW(AWB), .DW(WB), .BW(BEB), .HAS_CLEAR(IN_CLEARS)) u_in_b (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.aclr_in(in_aclr_in),
		.clken_in(in_clken_in),
		.addr_in(addr_b_in),
		.data_in(data_b_in),
		.byteen_in(byteen_b_in),
		.wren_in(wren_b_in),
		.rden_in(rden_b_in),
		.addr_out(rb_addr),
		.data_out(rb_data),
		.byteen_out(rb_be),
		.wren_out(rb_wren),
		.rden_out()
	);

	// falling-edge capture of read side for flow-through reads
	always_ff @(negedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fall_addr <= '0;
			fall_rden <= 1'b0;
		end else if (in_clken_in) begin
			fall_addr <= addr_b_in;
			fall_rden <= rden_b_in;
		end
	end

	// mode qualification of each port
	assign dual_ok = (SIZE != SIZE_SMALL);
	assign flow_ok = flow_through_in && (mode_in == MODE_SIMPLE_DUAL) && (SIZE != SIZE_LARGE);
	assign rd_addr_b = flow_ok ? fall_addr : rd_addr_q;
	assign rd_en_b = flow_ok ? fall_rden : rd_en_q;
	// port a writes in every mode but a single-port read without split; port b writes in true dual mode or when split, never in the small size
	assign en_wr_a = ra_wren && !(mode_in == MODE_SINGLE && ra_rden && !split_in);
	assign en_wr_b = rb_wren && (mode_in == MODE_TRUE_DUAL || split_in) && dual_ok;

	// write through self-timed strobe: registered enable on the clock edge
	always_ff @(posedge clk_in) begin
		if (PRELOAD && !rst_b_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= PRELOAD_WORD;
			end
		end else begin
			if (en_wr_a) begin
				for (int i = 0; i < WA; i++) begin
					if (!BYTE_ENABLES || ra_be[i / BYTE_BITS]) begin
						mem[ra_addr[AWA-1 -: AW]][(ra_addr % RATIO_A) * WA + i] <= ra_data[i];
					end
				end
			end
			if (en_wr_b) begin
				for (int i = 0; i < WB; i++) begin
					if (!BYTE_ENABLES || rb_be[i / BYTE_BITS]) begin
						mem[rb_addr[AWB-1 -: AW]][(rb_addr % RATIO_B) * WB + i] <= rb_data[i];
					end
				end
			end
		end
	end

	// read-side copy of port b address: a clear reaches the array read only at the next edge
	always_comb begin
		next_rd_addr_q = rd_addr_q;
		next_rd_en_q = rd_en_q;
		if (IN_CLEARS && in_aclr_in) begin
			next_rd_addr_q = '0;
			next_rd_en_q = 1'b0;
		end else if (in_clken_in) begin
			next_rd_addr_q = addr_b_in;
			next_rd_en_q = rden_b_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_addr_q <= '0;
			rd_en_q <= 1'b0;
		end else begin
			rd_addr_q <= next_rd_addr_q;
			rd_en_q <= next_rd_en_q;
		end
	end

	// port a write landing on the word port b reads at the same edge
	assign rdw_hit = en_wr_a && (ra_addr[AWB-1:0] == rd_addr_b);

	// array read words; single port shows the stored word after a write
	always_comb begin
		next_word_a = mem[ra_addr[AWA-1 -: AW]][(ra_addr % RATIO_A) * WA +: WA];
		next_word_b = mem[rd_addr_b[AWB-1 -: AW]][(rd_addr_b % RATIO_B) * WB +: WB];
		if (mode_in == MODE_SIMPLE_DUAL && rdw_select_in == RDW_UNDEFINED && rdw_hit && RATIO_A == RATIO_B) begin
			next_word_b = fill_word();
		end
		word_a = next_word_a;
		word_b = rd_en_b ? next_word_b : '0;
	end

	// output registers, bypassable; flow-through forces bypass on b
	ram_output_stage #(.DW(WA)) u_out_a (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.aclr_in(out_aclr_in),
		.clken_in(out_clken_in),
		.bypass_in(bypass_a_in),
		.array_in(word_a),
		.q_out(q_a_out)
	);

	ram_output_stage #(.DW(WB)) u_out_b (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.aclr_in(out_aclr_in),
		.clken_in(out_clken_in),
		.bypass_in(bypass_b_in || flow_ok),
		.array_in(word_b),
		.q_out(q_b_out)
	);

	// parity check of read data on port b
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			parity_err_b_out <= '0;
		end else if (out_clken_in && rd_en_b) begin
			parity_err_b_out <= parity_fail(word_b);
		end
	end
endmodule

// ===== tb/block_ram_checker_assertions.sv
// port checker of the configurable block ram
`timescale 1ns/1ps
module block_ram_checker
	import block_ram_pkg::*;
#(
	parameter int DEPTH = 128,
	parameter int WIDTH = 36,
	parameter int RATIO_A = 1,
	parameter int RATIO_B = 1
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [1:0] mode_in,
	input wire logic rdw_select_in,
	input wire logic bypass_a_in,
	input wire logic bypass_b_in,
	input wire logic in_aclr_in,
	input wire logic out_aclr_in,
	input wire logic in_clken_in,
	input wire logic out_clken_in,
	input wire logic [$clog2(DEPTH*RATIO_A)-1:0] addr_a_in,
	input wire logic wren_a_in,
	input wire logic [$clog2(DEPTH*RATIO_B)-1:0] addr_b_in,
	input wire logic rden_b_in,
	input wire logic [WIDTH/RATIO_A-1:0] q_a_out,
	input wire logic [WIDTH/RATIO_B-1:0] q_b_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// output clear and reset state
	clear_q_a: assert property (out_aclr_in |-> q_a_out == '0 && q_b_out == '0)
		else $error("q not cleared");
	reset_zero_a: assert property ($rose(rst_b_in) && !bypass_a_in && !bypass_b_in |-> q_a_out == '0)
		else $error("q not zero after reset");
	clear_stays_a: assert property ($fell(out_aclr_in) && !out_clken_in && !bypass_b_in |=> q_b_out == '0)
		else $error("cleared q changed without enable");
	clear_port_a: assert property (out_aclr_in ##1 (!out_aclr_in && !out_clken_in && !bypass_a_in)
		|=> q_a_out == '0) else $error("cleared q a changed without enable");
	// disabled output enable holds registered data
	hold_q_a: assert property ((!out_clken_in && !bypass_a_in && !out_aclr_in)[*2] |-> $stable(q_a_out))
		else $error("q a moved while disabled");
	hold_q_b_a: assert property (!out_clken_in && !bypass_b_in && !out_aclr_in
		|=> out_aclr_in || bypass_b_in || q_b_out == $past(q_b_out)) else $error("q b moved while disabled");
	hold_long_a: assert property ((!out_clken_in && !bypass_b_in && !out_aclr_in)[*4]
		|-> q_b_out == $past(q_b_out, 3)) else $error("q b drifted while disabled");
	// same-address read during write returns the fill pattern
	rdw_fill_a: assert property ((mode_in == MODE_SIMPLE_DUAL && rdw_select_in && wren_a_in && rden_b_in
		&& addr_a_in == addr_b_in && in_clken_in && !in_aclr_in ##1 mode_in == MODE_SIMPLE_DUAL
		&& rdw_select_in && out_clken_in && !out_aclr_in && !in_aclr_in && !bypass_b_in)
		|=> out_aclr_in || q_b_out == {(WIDTH/RATIO_B/BYTE_BITS){UNDEFINED_FILL}}) else $error("no fill");
endmodule
bind configurable_block_ram block_ram_checker #(.DEPTH(DEPTH), .WIDTH(WIDTH), .RATIO_A(RATIO_A),
	.RATIO_B(RATIO_B)) i_chk (.clk_in, .rst_b_in, .mode_in, .rdw_select_in, .bypass_a_in, .bypass_b_in,
	.in_aclr_in, .out_aclr_in, .in_clken_in, .out_clken_in, .addr_a_in, .wren_a_in, .addr_b_in,
	.rden_b_in, .q_a_out, .q_b_out);

// ===== tb/ram_user_logic.sv
// user logic model driving port a from its own registers
`timescale 1ns/1ps
module ram_user_logic (
	input wire logic clk_in,
	input wire logic req_we_in,
	input wire logic [6:0] req_addr_in,
	input wire logic [35:0] req_data_in,
	output logic wren_out,
	output logic rden_out,
	output logic [6:0] addr_out,
	output logic [35:0] data_out,
	output logic [3:0] byteen_out
);
	// write enable rests low
	initial begin
		wren_out = 1'h0;
		rden_out = 1'h0;
		addr_out = 7'h00;
		data_out = 36'h0;
		byteen_out = 4'hF;
	end
	// registered request, whole words, launched on the falling edge
	always @(negedge clk_in) begin
		wren_out <= req_we_in;
		if (req_we_in) begin
			addr_out <= req_addr_in;
			data_out <= req_data_in;
		end else begin
			data_out <= ~data_out; // idle data is not a stale word
		end
	end
endmodule

// ===== tb/configurable_block_ram_tb_top.sv
// self-checking testbench of the configurable block ram
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module configurable_block_ram_tb_top
	import block_ram_pkg::*;
;
	localparam logic [35:0] D5 = 36'h1_2345_6789;
	localparam logic [35:0] D6 = 36'hE_DCBA_9876;
	localparam logic [35:0] D7 = 36'h8_0000_0001;
	logic clk_in, rst_b_in, rdw_select_in, flow_through_in, bypass_a_in, bypass_b_in, split_in;
	logic in_aclr_in, out_aclr_in, in_clken_in, out_clken_in, wren_b_in, rden_b_in, req_we;
	logic [1:0] mode_in;
	logic [6:0] addr_b_in, req_addr, addr_a_in;
	logic [35:0] data_b_in, req_data, data_a_in, q_a_out, q_b_out, q;
	logic [3:0] byteen_b_in, byteen_a_in;
	logic [3:0] perr;
	logic wren_a_in, rden_a_in;
	int fails = 0;
	int check_count = 0;
	// partner on port a and the block itself
	ram_user_logic i_user (.clk_in, .req_we_in(req_we), .req_addr_in(req_addr), .req_data_in(req_data),
		.wren_out(wren_a_in), .rden_out(rden_a_in), .addr_out(addr_a_in), .data_out(data_a_in),
		.byteen_out(byteen_a_in));
	configurable_block_ram i_dut (.clk_in, .rst_b_in, .mode_in, .rdw_select_in, .flow_through_in,
		.bypass_a_in, .bypass_b_in, .split_in, .in_aclr_in, .out_aclr_in, .in_clken_in, .out_clken_in,
		.addr_a_in, .data_a_in, .byteen_a_in, .wren_a_in, .rden_a_in, .addr_b_in, .data_b_in,
		.byteen_b_in, .wren_b_in, .rden_b_in, .q_a_out, .q_b_out, .parity_err_b_out(perr));
	// 125 MHz clock
	initial begin
		clk_in = 1'h0;
		forever #4 clk_in = ~clk_in;
	end
	// port a write request and port b read, launched together
	task op(input logic we, input logic [6:0] aa, input logic [35:0] da, input logic rb, input logic [6:0] ab);
		@(posedge clk_in);
		req_we <= we;
		req_addr <= aa;
		req_data <= da;
		@(negedge clk_in);
		rden_b_in <= rb;
		addr_b_in <= ab;
		@(posedge clk_in);
		req_we <= 1'h0;
		@(negedge clk_in);
		rden_b_in <= 1'h0;
	endtask
	// registered read on port b
	task rd(input logic [6:0] a);
		op(1'h0, 7'h00, 36'h0, 1'h1, a);
		@(negedge clk_in);
		q = q_b_out;
	endtask
	// port b write with byte enables
	task wrb(input logic [6:0] a, input logic [35:0] d, input logic [3:0] be);
		@(negedge clk_in);
		wren_b_in <= 1'h1;
		addr_b_in <= a;
		data_b_in <= d;
		byteen_b_in <= be;
		@(negedge clk_in);
		wren_b_in <= 1'h0;
		data_b_in <= ~d;
	endtask
	task t_basic;
		`CHK(q_a_out, 36'h0)
		`CHK(q_b_out, 36'h0)
		op(1'h1, 7'h05, D5, 1'h0, 7'h00);
		op(1'h1, 7'h7F, D7, 1'h0, 7'h00);
		op(1'h1, 7'h06, D6, 1'h0, 7'h00);
		rd(7'h05);
		`CHK(q, D5)
		rd(7'h7F);
		`CHK(q, D7)
		@(negedge clk_in);
		bypass_b_in <= 1'h1;
		op(1'h0, 7'h00, 36'h0, 1'h1, 7'h06);
		`CHK(q_b_out, D6)
		in_aclr_in <= 1'h1;
		#1 `CHK(q_b_out, D6)
		@(negedge clk_in);
		in_aclr_in <= 1'h0;
		bypass_b_in <= 1'h0;
	endtask
	task t_hold;
		rd(7'h05);
		out_clken_in <= 1'h0;
		rd(7'h06);
		`CHK(q, D5)
		@(negedge clk_in);
		out_aclr_in <= 1'h1;
		#1 `CHK(q_b_out, 36'h0)
		`CHK(q_a_out, 36'h0)
		@(negedge clk_in);
		out_aclr_in <= 1'h0;
		@(negedge clk_in);
		`CHK(q_b_out, 36'h0)
		@(negedge clk_in);
		out_clken_in <= 1'h1;
	endtask
	task t_bytes;
		wrb(7'h09, 36'h0, 4'hF);
		wrb(7'h09, 36'hF_FFFF_FFFF, 4'h2);
		rd(7'h09);
		`CHK(q, 36'h0_0003_FE00)
		`CHK(perr, 4'hD)
		mode_in <= MODE_SIMPLE_DUAL;
		wrb(7'h09, 36'hF_FFFF_FFFF, 4'hF);
		rd(7'h09);
		`CHK(q, 36'h0_0003_FE00)
	endtask
	task t_rdw;
		op(1'h1, 7'h05, D6, 1'h1, 7'h05);
		@(negedge clk_in);
		`CHK(q_b_out, D5)
		rdw_select_in <= 1'h1;
		op(1'h1, 7'h05, D7, 1'h1, 7'h05);
		@(negedge clk_in);
		`CHK(q_b_out, {4{UNDEFINED_FILL}})
		rdw_select_in <= 1'h0;
		rd(7'h05);
		`CHK(q, D7)
	endtask
	// verdict and end of run
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (5000) @(posedge clk_in);
		fails++;
		end_sim;
	end
	// reset, then the scenarios
	initial begin
		{rst_b_in, rdw_select_in, flow_through_in, bypass_a_in, bypass_b_in, split_in} = '0;
		{in_aclr_in, out_aclr_in, wren_b_in, rden_b_in, req_we} = '0;
		{in_clken_in, out_clken_in} = 2'h3;
		mode_in = MODE_TRUE_DUAL;
		{addr_b_in, req_addr, data_b_in, req_data} = '0;
		byteen_b_in = 4'hF;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		rst_b_in <= 1'h1;
		@(negedge clk_in);
		t_basic;
		t_hold;
		t_bytes;
		t_rdw;
		end_sim;
	end
endmodule
